// >>> design/ebscs_ctrl.sv
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - ack pair: both high waits, low-only 8-bit, high-only 16-bit, both low reserved
// - long word takes two cycles from 16-bit port, four from 8-bit port
// - move maximum data per cycle; each word starts assuming 16-bit port
// - operand bytes numbered from most significant byte as zero
// - byte lanes routed from size outputs and address outputs
// - size outputs give operand bytes still to move this cycle
// - pin role 00 discrete, 01 alternate, 10 select 8-bit, 11 select 16-bit
// - pin role 0 bits 15:14 read zero, writes ignored
// - pin role 0 bit 1 reads one, writes ignored
// - seven 2-bit fields: selects 5..0 with alternates, lowest field boot
// - each select decodes a 2 Kbyte to 1 Mbyte block; overlap allowed
// - option register sets eight assertion parameters including wait states; code decodes only read enable, write enable and wait states
// - discrete latch drives select pins assigned as discrete outputs; code drives only selects 3..5 from the latch, selects 0..2 stay undriven
// - boot select with own base and option registers for initial fetch
// - acknowledge cycle goes external only when arbitration is won
// - acknowledge cycle drives function code all ones, level on address 3:1
module ebscs_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire ebscs_pkg::ebscs_req_s req,
  input wire logic iack_win,
  output logic req_ready,
  output logic resp_valid,
  output ebscs_pkg::ebscs_resp_s resp,
  output logic [23:0] addr_out,
  output logic [2:0] fc_out,
  output logic [1:0] xfer_size,
  output logic rw_out,
  output logic as_n,
  output logic ds_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic size_ack_low_n,
  input wire logic size_ack_high_n,
  input wire logic [2:0] boot_strap,
  output logic [5:0] sel_pin_o,
  output logic [5:0] sel_pin_oe,
  output logic boot_select_n
);
  localparam int N = ebscs_pkg::NSEL;

  logic [15:0] role0_reg;
  logic [2:0] dout_reg;
  logic [23:0] base_reg [N];
  logic [15:0] opt_reg [N];
  logic strap_done_reg;
  ebscs_pkg::ebscs_state_e state_reg;
  logic [23:0] addr_reg;
  logic [2:0] fc_reg;
  logic write_reg;
  logic iack_reg;
  logic [2:0] rem_reg;
  logic [31:0] acc_reg;
  logic [31:0] wsr_reg;
  logic [3:0] wcnt_reg;
  logic err_reg;
  logic port16_reg;

  logic [N-1:0] hit;
  logic [1:0] sel_role [N];
  logic [N-1:0] sel_act;
  logic hit_any;
  logic [2:0] hit_idx;
  logic [3:0] waitv;
  logic int_term;
  logic [1:0] ack_code;
  logic port16;
  logic [2:0] moved;
  logic [7:0] rd_byte;
  logic [2:0] tot;
  logic [2:0] wsh;
  logic cyc;

  // register bus
  logic wr_en;
  logic sel_page;
  logic [2:0] sel_idx;
  logic mapped;

  assign wr_en = psel && penable && pwrite && mapped;
  assign sel_page = (paddr[11:6] == ebscs_pkg::A_SEL_PAGE) && (paddr[5:3] < 3'(N));
  assign sel_idx = paddr[5:3];
  assign mapped = sel_page || (paddr == ebscs_pkg::A_ROLE0) || (paddr == ebscs_pkg::A_DOUT)
    || (paddr == ebscs_pkg::A_STAT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    prdata = 32'h00000000;
    if (sel_page) begin
      prdata = paddr[2] ? {16'h0000, opt_reg[sel_idx]} : {8'h00, base_reg[sel_idx]};
    end else if (paddr == ebscs_pkg::A_ROLE0) begin
      prdata = {16'h0000, role0_reg};
    end else if (paddr == ebscs_pkg::A_DOUT) begin
      prdata = {29'h00000000, dout_reg};
    end else if (paddr == ebscs_pkg::A_STAT) begin
      prdata = {29'h00000000, port16_reg, err_reg, state_reg != ebscs_pkg::ST_IDLE};
    end
  end

  // straps are caught in the first cycle after release, never under the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role0_reg <= ebscs_pkg::ROLE0_RST;
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
      if (wr_en && paddr == ebscs_pkg::A_ROLE0) begin
        role0_reg <= (pwdata[15:0] & ebscs_pkg::ROLE0_WMASK) | ebscs_pkg::ROLE0_ONES;
      end else if (!strap_done_reg) begin
        role0_reg <= {2'b00, {3{boot_strap[2], 1'b1}}, {3{boot_strap[1], 1'b1}},
          1'b1, boot_strap[0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_reg <= 3'h0;
    end else if (wr_en && paddr == ebscs_pkg::A_DOUT) begin
      dout_reg <= pwdata[2:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_sel
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          base_reg[gi] <= (gi == 0) ? ebscs_pkg::BOOT_BASE_RST : ebscs_pkg::SEL_BASE_RST;
          opt_reg[gi] <= (gi == 0) ? ebscs_pkg::BOOT_OPT_RST : ebscs_pkg::SEL_OPT_RST;
        end else if (wr_en && sel_page && sel_idx == 3'(gi)) begin
          if (paddr[2]) begin
            opt_reg[gi] <= pwdata[15:0];
          end else begin
            base_reg[gi] <= pwdata[23:0] & ebscs_pkg::BASE_MASK;
          end
        end
      end
      // field 0 is boot, field k+1 drives select k
      assign sel_role[gi] = role0_reg[2*gi+1:2*gi];
      ebscs_match u_match (
        .addr(addr_reg),
        .write(write_reg),
        .base(base_reg[gi]),
        .opt(opt_reg[gi]),
        .hit(hit[gi])
      );
      // overlapping blocks all assert their pins
      assign sel_act[gi] = cyc && !iack_reg && hit[gi] && sel_role[gi][1];
    end
    for (gi = 0; gi < ebscs_pkg::NPIN; gi++) begin : g_pin
      always_comb begin
        sel_pin_o[gi] = 1'b1;
        sel_pin_oe[gi] = 1'b1;
        case (sel_role[gi+1])
          ebscs_pkg::ROLE_DISC: begin
            // only selects 3..5 have a discrete output
            sel_pin_o[gi] = (gi >= 3) ? dout_reg[gi%3] : 1'b1;
            sel_pin_oe[gi] = (gi >= 3);
          end
          ebscs_pkg::ROLE_ALT: begin
            // arbitration pins on selects 0..2 belong to another block
            sel_pin_o[gi] = (gi >= 3) ? fc_out[gi%3] : 1'b1;
            sel_pin_oe[gi] = (gi >= 3);
          end
          default: begin
            sel_pin_o[gi] = !sel_act[gi+1];
          end
        endcase
      end
    end
  endgenerate

  assign boot_select_n = !sel_act[0];

  // lowest index wins the termination choice when blocks overlap
  always_comb begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit[i] && sel_role[i][1] && !iack_reg) begin
        hit_any = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  assign waitv = opt_reg[hit_idx][ebscs_pkg::OPT_WAIT_LSB+3:ebscs_pkg::OPT_WAIT_LSB];
  assign int_term = hit_any && (waitv != ebscs_pkg::WAIT_EXT);

  always_comb begin
    if (int_term) begin
      if (wcnt_reg == waitv) begin
        ack_code = sel_role[hit_idx][0] ? ebscs_pkg::ACK_16 : ebscs_pkg::ACK_8;
      end else begin
        ack_code = ebscs_pkg::ACK_WAIT;
      end
    end else begin
      ack_code = {size_ack_high_n, size_ack_low_n};
    end
  end

  assign port16 = ack_code == ebscs_pkg::ACK_16;
  // a 16-bit port takes two bytes only from an even address
  assign moved = (port16 && !addr_reg[0] && rem_reg >= 3'h2) ? 3'h2 : 3'h1;
  // 8-bit port lives on the high lane; odd byte of 16-bit port on the low lane
  assign rd_byte = (port16 && addr_reg[0]) ? data_in[7:0] : data_in[15:8];
  assign tot = req.iack ? 3'h1 : ebscs_pkg::siz_bytes(req.size);
  assign wsh = 3'h4 - tot;
  assign cyc = (state_reg == ebscs_pkg::ST_ADDR) || (state_reg == ebscs_pkg::ST_WAIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ebscs_pkg::ST_IDLE;
      wcnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ebscs_pkg::ST_IDLE: begin
          if (req_valid) begin
            // a lost arbitration never asserts as_n or ds_n
            state_reg <= (req.iack && !iack_win) ? ebscs_pkg::ST_DONE : ebscs_pkg::ST_ADDR;
          end
        end
        ebscs_pkg::ST_ADDR: begin
          state_reg <= ebscs_pkg::ST_WAIT;
          wcnt_reg <= 4'h0;
        end
        ebscs_pkg::ST_WAIT: begin
          wcnt_reg <= wcnt_reg + 4'h1;
          if (ack_code == ebscs_pkg::ACK_RSV) begin
            state_reg <= ebscs_pkg::ST_DONE;
          end else if (ack_code != ebscs_pkg::ACK_WAIT) begin
            state_reg <= (rem_reg == moved) ? ebscs_pkg::ST_DONE : ebscs_pkg::ST_ADDR;
          end
        end
        ebscs_pkg::ST_DONE: begin
          state_reg <= ebscs_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= ebscs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 24'h000000;
      fc_reg <= 3'h0;
      write_reg <= 1'b0;
      iack_reg <= 1'b0;
      rem_reg <= 3'h0;
      acc_reg <= 32'h00000000;
      wsr_reg <= 32'h00000000;
      err_reg <= 1'b0;
      port16_reg <= 1'b0;
    end else if (state_reg == ebscs_pkg::ST_IDLE && req_valid) begin
      iack_reg <= req.iack;
      write_reg <= req.write && !req.iack;
      err_reg <= req.iack && !iack_win;
      rem_reg <= tot;
      acc_reg <= 32'h00000000;
      // byte zero of the operand sits at the top of the shift register
      wsr_reg <= req.wdata << {wsh, 3'b000};
      if (req.iack) begin
        addr_reg <= {ebscs_pkg::IACK_HI, req.level, 1'b1};
        fc_reg <= ebscs_pkg::FC_CPU;
      end else begin
        addr_reg <= req.addr;
        fc_reg <= req.fc;
      end
    end else if (state_reg == ebscs_pkg::ST_WAIT) begin
      if (ack_code == ebscs_pkg::ACK_RSV) begin
        err_reg <= 1'b1;
      end else if (ack_code != ebscs_pkg::ACK_WAIT) begin
        port16_reg <= port16;
        rem_reg <= rem_reg - moved;
        addr_reg <= addr_reg + {21'h000000, moved};
        if (moved == 3'h2) begin
          acc_reg <= {acc_reg[15:0], data_in};
          wsr_reg <= {wsr_reg[15:0], 16'h0000};
        end else begin
          acc_reg <= {acc_reg[23:0], rd_byte};
          wsr_reg <= {wsr_reg[23:0], 8'h00};
        end
      end
    end
  end

  assign req_ready = state_reg == ebscs_pkg::ST_IDLE;
  assign resp_valid = state_reg == ebscs_pkg::ST_DONE;
  assign resp.err = err_reg;
  assign resp.rdata = acc_reg;
  assign addr_out = addr_reg;
  assign fc_out = fc_reg;
  assign xfer_size = rem_reg[1:0];
  assign rw_out = !write_reg;
  assign as_n = !cyc;
  assign ds_n = state_reg != ebscs_pkg::ST_WAIT;
  // odd byte copied to both lanes so either port width sees it
  assign data_out = addr_reg[0] ? {2{wsr_reg[31:24]}} : wsr_reg[31:16];
  assign data_oe = cyc && write_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take;
    state_reg == ebscs_pkg::ST_IDLE && req_valid;
  endsequence

  sequence s_ext_wait;
    state_reg == ebscs_pkg::ST_WAIT && !int_term;
  endsequence

  property p_ack_hold;
    s_ext_wait and {size_ack_high_n, size_ack_low_n} == ebscs_pkg::ACK_WAIT
      |=> state_reg == ebscs_pkg::ST_WAIT && $stable(rem_reg);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("wait ack did not hold cycle");

  property p_rsv;
    s_ext_wait and {size_ack_high_n, size_ack_low_n} == ebscs_pkg::ACK_RSV
      |=> resp_valid && resp.err ##1 state_reg == ebscs_pkg::ST_IDLE;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved ack not ended as error");

  property p_long8;
    state_reg == ebscs_pkg::ST_WAIT && ack_code == ebscs_pkg::ACK_8 && rem_reg == 3'h4
      |=> rem_reg == 3'h3 && acc_reg[7:0] == $past(data_in[15:8]);
  endproperty
  a_long8: assert property (p_long8) else $error("8-bit ack moved wrong amount");

  property p_long16;
    state_reg == ebscs_pkg::ST_WAIT && port16 && rem_reg == 3'h4 && !addr_reg[0]
      |=> rem_reg == 3'h2 && acc_reg[15:0] == $past(data_in) ##1 xfer_size == ebscs_pkg::SIZ_WORD;
  endproperty
  a_long16: assert property (p_long16) else $error("16-bit ack misrouted");

  property p_start;
    s_take and !req.iack |=> xfer_size == $past(req.size) && addr_out == $past(req.addr)
      && !as_n;
  endproperty
  a_start: assert property (p_start) else $error("cycle start size or address wrong");

  property p_iack;
    s_take and req.iack && iack_win |=> fc_out == ebscs_pkg::FC_CPU
      && addr_out == {ebscs_pkg::IACK_HI, $past(req.level), 1'b1} && xfer_size == ebscs_pkg::SIZ_BYTE;
  endproperty
  a_iack: assert property (p_iack) else $error("acknowledge cycle address wrong");

  property p_iack_lose;
    s_take and req.iack && !iack_win |=> as_n && resp_valid && resp.err;
  endproperty
  a_iack_lose: assert property (p_iack_lose) else $error("lost acknowledge went external");

  property p_role_fixed;
    strap_done_reg |-> role0_reg[15:14] == 2'b00 && role0_reg[1];
  endproperty
  a_role_fixed: assert property (p_role_fixed) else $error("fixed role bits changed");

  property p_disc;
    sel_role[4] == ebscs_pkg::ROLE_DISC |-> sel_pin_oe[3] && sel_pin_o[3] == dout_reg[0];
  endproperty
  a_disc: assert property (p_disc) else $error("discrete pin not from latch");

  property p_boot;
    !boot_select_n |-> cyc && hit[0] && !iack_reg;
  endproperty
  a_boot: assert property (p_boot) else $error("boot select outside its block");
endmodule
`default_nettype wire

// >>> design/ebscs_match.sv
`timescale 1ns/10ps
`default_nettype none
module ebscs_match (
  input wire logic [23:0] addr,
  input wire logic write,
  input wire logic [23:0] base,
  input wire logic [15:0] opt,
  output logic hit
);
  logic [3:0] bsz;
  logic [23:0] low;
  logic in_blk;
  logic dir_ok;

  // codes above the 1 Mbyte step saturate there
  assign bsz = (base[3:0] > ebscs_pkg::BSZ_MAX) ? ebscs_pkg::BSZ_MAX : base[3:0];
  assign low = (ebscs_pkg::BLK_MIN << bsz) - 24'h000001;
  assign in_blk = (((addr ^ base) & ~low) >> ebscs_pkg::BASE_LSB) == 24'h000000;
  assign dir_ok = write ? opt[ebscs_pkg::OPT_WR] : opt[ebscs_pkg::OPT_RD];
  assign hit = in_blk && dir_ok;
endmodule
`default_nettype wire

// >>> design/ebscs_pkg.sv
package ebscs_pkg;
  // boot select plus six general chip selects
  localparam int NSEL = 7;
  localparam int NPIN = 6;
  // register byte addresses
  localparam logic [11:0] A_ROLE0 = 12'h000;
  localparam logic [11:0] A_DOUT = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [5:0] A_SEL_PAGE = 6'h01;
  // pin role register layout
  localparam logic [15:0] ROLE0_RST = 16'h3FFF;
  localparam logic [15:0] ROLE0_WMASK = 16'h3FFD;
  localparam logic [15:0] ROLE0_ONES = 16'h0002;
  localparam logic [1:0] ROLE_DISC = 2'h0;
  localparam logic [1:0] ROLE_ALT = 2'h1;
  localparam logic [1:0] ROLE_CS8 = 2'h2;
  localparam logic [1:0] ROLE_CS16 = 2'h3;
  // {size_ack_high_n, size_ack_low_n}
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_8 = 2'h2;
  localparam logic [1:0] ACK_16 = 2'h1;
  localparam logic [1:0] ACK_RSV = 2'h0;
  // transfer size codes, bytes still to move
  localparam logic [1:0] SIZ_LONG = 2'h0;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] SIZ_WORD = 2'h2;
  // base address register: [23:11] block base, [3:0] block size code
  localparam int BASE_LSB = 11;
  localparam logic [3:0] BSZ_MAX = 4'h9;
  localparam logic [23:0] BLK_MIN = 24'h000800;
  localparam logic [23:0] BASE_MASK = 24'hFFF80F;
  // option register: [12] write enable, [11] read enable, [9:6] wait states
  localparam int OPT_WR = 12;
  localparam int OPT_RD = 11;
  localparam int OPT_WAIT_LSB = 6;
  localparam logic [3:0] WAIT_EXT = 4'hF;
  localparam logic [23:0] BOOT_BASE_RST = 24'h000009;
  localparam logic [15:0] BOOT_OPT_RST = 16'h1BC0;
  localparam logic [23:0] SEL_BASE_RST = 24'h000000;
  localparam logic [15:0] SEL_OPT_RST = 16'h0000;
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [19:0] IACK_HI = 20'hFFFFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } ebscs_state_e;

  typedef struct packed {
    logic iack;
    logic [2:0] level;
    logic write;
    logic [1:0] size;
    logic [2:0] fc;
    logic [23:0] addr;
    logic [31:0] wdata;
  } ebscs_req_s;

  typedef struct packed {
    logic err;
    logic [31:0] rdata;
  } ebscs_resp_s;

  function automatic logic [2:0] siz_bytes(input logic [1:0] s);
    return (s == SIZ_LONG) ? 3'h4 : {1'b0, s};
  endfunction
endpackage

// >>> dv/ebscs_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ebscs_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ds_n,
  input wire logic rw_out,
  input wire logic [23:0] addr_out,
  input wire logic [1:0] xfer_size,
  input wire logic [15:0] data_out,
  input wire logic port16,
  input wire logic rsv_ack,
  input wire logic [1:0] delay,
  output logic [15:0] data_in,
  output logic size_ack_low_n,
  output logic size_ack_high_n
);
  logic [7:0] mem [0:255];
  logic [2:0] wait_cnt;
  logic [15:0] last_q;
  logic [15:0] rd;
  logic [7:0] a;
  logic ack_on;
  assign a = addr_out[7:0];
  assign ack_on = !ds_n && (wait_cnt >= {1'b0, delay});
  // a 16-bit port answers as 16-bit even for byte operations
  assign {size_ack_high_n, size_ack_low_n} = !ack_on ? ebscs_pkg::ACK_WAIT :
    rsv_ack ? ebscs_pkg::ACK_RSV : port16 ? ebscs_pkg::ACK_16 : ebscs_pkg::ACK_8;
  // lanes the port does not own show the inverse of the last value
  assign rd = !port16 ? {mem[a], ~last_q[7:0]} :
    a[0] ? {~last_q[15:8], mem[a]} : {mem[a], mem[a + 8'h01]};
  // the interrupt vector is served like read data of the addressed byte
  assign data_in = (ack_on && rw_out) ? rd : ~last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 3'h0;
      last_q <= 16'h0000;
    end else begin
      wait_cnt <= ds_n ? 3'h0 : wait_cnt + 3'h1;
      last_q <= data_in;
    end
  end
  always @(posedge pclk) begin
    if (ack_on && !rw_out && !rsv_ack) begin
      if (!port16) begin
        mem[a] <= data_out[15:8];
      end else if (a[0]) begin
        mem[a] <= data_out[7:0];
      end else begin
        mem[a] <= data_out[15:8];
        if (xfer_size != ebscs_pkg::SIZ_BYTE) begin
          mem[a + 8'h01] <= data_out[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/test_external_bus_sizing_chip_select.sv
`timescale 1ns/10ps
`default_nettype none
module test_external_bus_sizing_chip_select;
  logic pclk, presetn, psel, penable, pwrite, req_valid, iack_win, port16, rsv_ack;
  logic pready, pslverr, req_ready, resp_valid, rw_out, as_n, ds_n, data_oe, e;
  logic size_ack_low_n, size_ack_high_n, boot_select_n, exp_iack, exp_wr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, w, wd;
  logic [23:0] addr_out, exp_addr, ad;
  logic [2:0] fc_out, exp_rem, moved, strap;
  logic [1:0] xfer_size, delay, sz;
  logic [15:0] data_in, data_out;
  logic [5:0] sel_pin_o, sel_pin_oe;
  logic [7:0] v;
  ebscs_pkg::ebscs_req_s req;
  ebscs_pkg::ebscs_resp_s resp, rs;
  int n_errors, checked, n_bus, seed, nb, n_ds;

  ebscs_ctrl ebscs_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req(req), .iack_win(iack_win),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .addr_out(addr_out),
    .fc_out(fc_out), .xfer_size(xfer_size), .rw_out(rw_out), .as_n(as_n), .ds_n(ds_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .size_ack_low_n(size_ack_low_n), .size_ack_high_n(size_ack_high_n),
    .boot_strap(strap), .sel_pin_o(sel_pin_o), .sel_pin_oe(sel_pin_oe),
    .boot_select_n(boot_select_n));
  ebscs_mem ebscs_mem_inst (.pclk(pclk), .presetn(presetn), .ds_n(ds_n), .rw_out(rw_out),
    .addr_out(addr_out), .xfer_size(xfer_size), .data_out(data_out), .port16(port16),
    .rsv_ack(rsv_ack), .delay(delay), .data_in(data_in),
    .size_ack_low_n(size_ack_low_n), .size_ack_high_n(size_ack_high_n));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic int n_bytes(input logic [1:0] s);
    return (s == 2'h0) ? 4 : int'(s);
  endfunction

  task cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task bus_op(input logic ia, input logic [2:0] lv, input logic wr, input logic [1:0] s,
              input logic [23:0] a, input logic [31:0] d, input logic win);
    ebscs_pkg::ebscs_req_s r;
    r = '0;
    r.iack = ia;
    r.level = lv;
    r.write = wr;
    r.size = s;
    r.fc = 3'h5;
    r.addr = a;
    r.wdata = d;
    exp_iack = ia;
    exp_rem = ia ? 3'h1 : 3'(n_bytes(s));
    exp_addr = ia ? {ebscs_pkg::IACK_HI, lv, 1'b1} : a;
    exp_wr = wr && !ia;
    n_bus = 0;
    n_ds = 0;
    @(posedge pclk);
    req <= r;
    req_valid <= 1'b1;
    iack_win <= win;
    do begin
      @(posedge pclk);
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin
      @(posedge pclk);
    end while (resp_valid !== 1'b1);
    rs = resp;
  endtask

  // each address phase is checked against the bytes still owed
  always @(posedge pclk) begin
    if (presetn && !as_n && ds_n) begin
      n_bus++;
      cmp_val("xfer_size", {30'h0, exp_rem[1:0]}, {30'h0, xfer_size});
      cmp_val("addr_out", {8'h0, exp_addr}, {8'h0, addr_out});
      cmp_val("data_oe", {31'h0, exp_wr}, {31'h0, data_oe});
      cmp_val("rw_out", {31'h0, !exp_wr}, {31'h0, rw_out});
      if (exp_iack) cmp_val("fc_out", {29'h0, ebscs_pkg::FC_CPU}, {29'h0, fc_out});
      moved = (port16 && !exp_addr[0] && exp_rem >= 3'h2) ? 3'h2 : 3'h1;
      exp_rem = exp_rem - moved;
      exp_addr = exp_addr + {21'h0, moved};
    end
    if (presetn && !ds_n) begin
      n_ds++;
      cmp_val("boot_select_n", {31'h0, exp_iack}, {31'h0, boot_select_n});
    end
  end

  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end

  initial begin
    seed = 2;
    strap = 3'($random(seed));
    n_errors = 0;
    checked = 0;
    n_bus = 0;
    exp_iack = 1'b0;
    exp_rem = 3'h0;
    exp_addr = 24'h0;
    {presetn, psel, penable, pwrite, req_valid, iack_win, rsv_ack} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    req = '0;
    port16 = 1'b1;
    delay = 2'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ebscs_pkg::A_ROLE0, 32'h0);
    cmp_val("strap role", {16'h0, 2'b00, {3{strap[2], 1'b1}}, {3{strap[1], 1'b1}}, 1'b1, strap[0]},
            q);
    apb(1'b0, 12'h040, 32'h0);
    cmp_val("boot base", {8'h0, ebscs_pkg::BOOT_BASE_RST}, q);
    apb(1'b0, 12'h044, 32'h0);
    cmp_val("boot options", {16'h0, ebscs_pkg::BOOT_OPT_RST}, q);
    for (int i = 1; i < 7; i++) begin
      apb(1'b0, 12'h040 + 12'(8 * i), 32'h0);
      cmp_val("base reset", {8'h0, ebscs_pkg::SEL_BASE_RST}, q);
      w = $random(seed);
      apb(1'b1, 12'h040 + 12'(8 * i), w);
      apb(1'b0, 12'h040 + 12'(8 * i), 32'h0);
      cmp_val("base", w & {8'h0, ebscs_pkg::BASE_MASK}, q);
      apb(1'b1, 12'h044 + 12'(8 * i), w);
      apb(1'b0, 12'h044 + 12'(8 * i), 32'h0);
      cmp_val("options", {16'h0, w[15:0]}, q);
      apb(1'b1, 12'h040 + 12'(8 * i), 32'h0);
      apb(1'b1, 12'h044 + 12'(8 * i), 32'h0);
    end
    apb(1'b0, 12'h078, 32'h0);
    cmp_val("unmapped pslverr", 32'h1, {31'h0, e});
    for (int t = 0; t < 10; t++) begin
      w = (t == 0) ? 32'hFFFFFFFF : (t == 1) ? 32'h0 : $random(seed);
      apb(1'b1, ebscs_pkg::A_ROLE0, w);
      apb(1'b0, ebscs_pkg::A_ROLE0, 32'h0);
      cmp_val("pin role 0", {16'h0, (w[15:0] & ebscs_pkg::ROLE0_WMASK) | ebscs_pkg::ROLE0_ONES}, q);
    end
    $display("test registers done");
    w = $random(seed);
    apb(1'b1, ebscs_pkg::A_ROLE0, 32'h000000FF);
    apb(1'b1, ebscs_pkg::A_DOUT, w);
    apb(1'b0, ebscs_pkg::A_DOUT, 32'h0);
    cmp_val("latch", {29'h0, w[2:0]}, {29'h0, q[2:0]});
    @(negedge pclk);
    cmp_val("discrete pins", {29'h0, w[2:0]}, {29'h0, sel_pin_o[5:3]});
    cmp_val("select oe", 32'h7, {29'h0, sel_pin_oe[2:0]});
    apb(1'b1, ebscs_pkg::A_ROLE0, 32'h00000003);
    @(negedge pclk);
    cmp_val("discrete oe", 32'h0, {29'h0, sel_pin_oe[2:0]});
    apb(1'b1, ebscs_pkg::A_ROLE0, 32'h00003FFF);
    $display("test pins done");
    for (int t = 0; t < 30; t++) begin
      sz = (t < 8) ? t[1:0] : 2'($random(seed));
      port16 <= (t < 8) ? t[2] : 1'($random(seed));
      delay <= 2'($random(seed));
      ad = (t < 8) ? 24'h10 + 24'(t) : {17'h0, 7'($random(seed))};
      nb = n_bytes(sz);
      wd = $random(seed);
      if (nb != 4) wd = wd & ((32'h1 << (8 * nb)) - 32'h1);
      bus_op(1'b0, 3'h0, 1'b1, sz, ad, wd, 1'b0);
      cmp_val("write err", 32'h0, {31'h0, rs.err});
      cmp_val("write bytes left", 32'h0, {29'h0, exp_rem});
      for (int b = 0; b < nb; b++) begin
        cmp_val("mem byte", {24'h0, wd[8 * (nb - 1 - b) +: 8]},
                {24'h0, ebscs_mem_inst.mem[ad[7:0] + 8'(b)]});
      end
      bus_op(1'b0, 3'h0, 1'b0, sz, ad, 32'h0, 1'b0);
      cmp_val("read data", wd, rs.rdata);
      cmp_val("read bytes left", 32'h0, {29'h0, exp_rem});
    end
    port16 <= 1'b1;
    rsv_ack <= 1'b1;
    bus_op(1'b0, 3'h0, 1'b0, ebscs_pkg::SIZ_BYTE, 24'h20, 32'h0, 1'b0);
    cmp_val("reserved err", 32'h1, {31'h0, rs.err});
    // boot select ends its own cycle after two waits, so the reserved ack must be ignored
    apb(1'b1, 12'h044, 32'h00001880);
    delay <= 2'h0;
    wd = $random(seed);
    ebscs_mem_inst.mem[8'h30] = wd[15:8];
    ebscs_mem_inst.mem[8'h31] = wd[7:0];
    bus_op(1'b0, 3'h0, 1'b0, ebscs_pkg::SIZ_WORD, 24'h30, 32'h0, 1'b0);
    cmp_val("internal read", {16'h0, wd[15:0]}, rs.rdata);
    cmp_val("internal err", 32'h0, {31'h0, rs.err});
    cmp_val("internal waits", 32'h3, n_ds);
    apb(1'b0, ebscs_pkg::A_STAT, 32'h0);
    cmp_val("status", 32'h4, q);
    apb(1'b1, 12'h044, {16'h0, ebscs_pkg::BOOT_OPT_RST});
    // function code of the last request is 5
    apb(1'b1, ebscs_pkg::A_ROLE0, 32'h000015FF);
    @(negedge pclk);
    cmp_val("alternate pins", 32'h5, {29'h0, sel_pin_o[5:3]});
    apb(1'b1, ebscs_pkg::A_ROLE0, 32'h00003FFF);
    rsv_ack <= 1'b0;
    $display("test transfers done");
    for (int l = 1; l < 8; l++) begin
      v = 8'($random(seed));
      ebscs_mem_inst.mem[{4'hF, 3'(l), 1'b1}] = v;
      bus_op(1'b1, 3'(l), 1'b0, ebscs_pkg::SIZ_BYTE, 24'h0, 32'h0, 1'b1);
      cmp_val("vector", {24'h0, v}, {24'h0, rs.rdata[7:0]});
      cmp_val("iack err", 32'h0, {31'h0, rs.err});
    end
    bus_op(1'b1, 3'h3, 1'b0, ebscs_pkg::SIZ_BYTE, 24'h0, 32'h0, 1'b0);
    cmp_val("lost iack err", 32'h1, {31'h0, rs.err});
    cmp_val("lost iack cycles", 32'h0, n_bus);
    $display("test iack done");
    print_verdict;
  end
endmodule
`default_nettype wire
